// *** verilog/phase_power_zone_config_regs.sv ***
`timescale 1ns/1ns
module phase_power_zone_config_regs #(
  parameter int SHED_STEP = zone_cfg_pkg::SHED_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [1:0] power_save_input,
  input wire logic [7:0] phase_enabled,
  input wire logic [2:0] zone_strap_a,
  input wire logic [2:0] zone_strap_b,
  input wire logic [7:0] shed_strap1,
  input wire logic [7:0] shed_strap2,
  input wire logic [7:0] shed_strap3,
  input wire logic [7:0] shed_strap4,
  input wire logic [3:0] shed_strap_over_2v,
  input wire logic [7:0] output_current_reading,
  input wire logic [7:0] sense_voltage_code,
  input wire logic [7:0] stage_thermal_code,
  input wire logic stage_thermal_fault,
  input wire logic die_thermal_fault,
  output logic [4:0] zone_gate,
  output logic [2:0] low_zone_level_a,
  output logic [1:0] low_zone_level_b,
  output logic [1:0] load_line_select,
  output logic [2:0] shed_level,
  output logic switching_frequency_select,
  output logic soft_start_from_reg,
  output logic per_phase_current_limit,
  output logic die_thermal_enable,
  output logic fault_latched_off,
  output logic fault_hiccup
);
  localparam int SYNC_W = 2 + 8 + 3 + 3 + 32 + 4 + 8 + 8 + 8 + 2;
  localparam int DLY_W = 28;

  // raw pins joined so one two-stage synchroniser covers them
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_meta; // first stage, read only by second stage
  logic [SYNC_W-1:0] sync_q;
  assign sync_raw = {power_save_input, phase_enabled, zone_strap_a, zone_strap_b,
    shed_strap1, shed_strap2, shed_strap3, shed_strap4, shed_strap_over_2v,
    output_current_reading, sense_voltage_code, stage_thermal_code,
    stage_thermal_fault, die_thermal_fault};

  // synchronised views
  logic [1:0] save_s;
  logic [7:0] phase_s;
  logic [2:0] strap_a_s;
  logic [2:0] strap_b_s;
  logic [7:0] strap_s [4];
  logic [3:0] over_s;
  logic [7:0] iout_s;
  logic [7:0] sense_v_s;
  logic [7:0] stage_t_s;
  logic stage_fault_s;
  logic die_fault_s;
  assign {save_s, phase_s, strap_a_s, strap_b_s, strap_s[0], strap_s[1], strap_s[2],
    strap_s[3], over_s, iout_s, sense_v_s, stage_t_s, stage_fault_s, die_fault_s} = sync_q;

  // software registers
  logic [4:0] zone_enables;
  logic [5:0] zone_config;
  logic [5:0] zone_status; // strapped codes
  logic [1:0] load_line;
  logic [7:0] shed_cfg [4];
  logic [7:0] shed_sts [4];
  logic [7:0] shed_hyst;
  logic [7:0] shed_delay;
  logic [7:0] latch_a;
  logic [7:0] latch_b;
  logic [7:0] source_sel; // selection in force
  logic stage_resp;
  logic [1:0] die_cfg;

  // strap capture sequencing
  logic [1:0] settle_cnt;
  logic straps_loaded;

  // shedding engine
  zone_cfg_pkg::shed_state_t shed_state;
  logic [DLY_W-1:0] shed_timer;
  logic [DLY_W-1:0] delay_cycles;
  logic [7:0] thr [4];
  logic [2:0] up_count;
  logic [2:0] down_count;

  // fault edge detection, next zone levels
  logic stage_fault_d;
  logic die_fault_d;
  logic [2:0] next_level_a;
  logic [1:0] next_level_b;

  // first zone field: in range passes, reserved holds old level
  function automatic logic [2:0] level_a_of(input logic [2:0] code, input logic [2:0] prev);
    level_a_of = (code <= zone_cfg_pkg::ZONE_A_MAX) ? code : prev;
  endfunction : level_a_of

  // second zone field: 100 also maps to top level
  function automatic logic [1:0] level_b_of(input logic [2:0] code, input logic [1:0] prev);
    if (code == zone_cfg_pkg::ZONE_B_MAX)
      level_b_of = zone_cfg_pkg::ZONE_B_TOP;
    else if (code < zone_cfg_pkg::ZONE_B_MAX)
      level_b_of = code[1:0];
    else
      level_b_of = prev;
  endfunction : level_b_of

  // two flip-flops before any logic looks at pins
  always_ff @(posedge sys_clk)
  begin
    sync_meta <= sync_raw;
    sync_q <= sync_meta;
  end

  // wait for sync pipe to fill, then catch straps once
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      settle_cnt <= 2'h0;
      straps_loaded <= 1'b0;
      zone_status <= 6'h00;
      for (int i = 0; i < 4; i++)
        shed_sts[i] <= 8'h00;
    end
    else if (!straps_loaded)
    begin
      if (settle_cnt == zone_cfg_pkg::STRAP_SETTLE)
      begin
        straps_loaded <= 1'b1;
        zone_status <= {strap_a_s, strap_b_s};
        for (int i = 0; i < 4; i++)
          shed_sts[i] <= over_s[i] ? zone_cfg_pkg::SHED_OFF : strap_s[i];
      end
      else
        settle_cnt <= settle_cnt + 2'h1;
    end
  end

  // writable registers; reserved bits are never stored
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      zone_enables <= zone_cfg_pkg::ZONE_ENABLES_RST;
      zone_config <= zone_cfg_pkg::ZONE_CONFIG_RST;
      load_line <= zone_cfg_pkg::LOAD_LINE_RST;
      for (int i = 0; i < 4; i++)
        shed_cfg[i] <= zone_cfg_pkg::SHED_CFG_RST;
      shed_hyst <= zone_cfg_pkg::SHED_HYST_RST;
      shed_delay <= zone_cfg_pkg::SHED_DELAY_RST;
      latch_a <= zone_cfg_pkg::LATCH_RST;
      latch_b <= zone_cfg_pkg::LATCH_RST;
      stage_resp <= 1'b0;
      die_cfg <= 2'h0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        zone_cfg_pkg::ADDR_ZONE_ENABLES: zone_enables <= reg_wdata[4:0];
        zone_cfg_pkg::ADDR_ZONE_CONFIG: zone_config <= reg_wdata[5:0];
        zone_cfg_pkg::ADDR_LOAD_LINE: load_line <= reg_wdata[1:0];
        zone_cfg_pkg::ADDR_SHED_CFG1: shed_cfg[0] <= reg_wdata;
        zone_cfg_pkg::ADDR_SHED_CFG2: shed_cfg[1] <= reg_wdata;
        zone_cfg_pkg::ADDR_SHED_CFG3: shed_cfg[2] <= reg_wdata;
        zone_cfg_pkg::ADDR_SHED_CFG4: shed_cfg[3] <= reg_wdata;
        zone_cfg_pkg::ADDR_SHED_HYST: shed_hyst <= reg_wdata;
        zone_cfg_pkg::ADDR_SHED_DELAY: shed_delay <= reg_wdata;
        zone_cfg_pkg::ADDR_LATCH_A: latch_a <= reg_wdata & zone_cfg_pkg::LATCH_MASK;
        zone_cfg_pkg::ADDR_LATCH_B: latch_b <= reg_wdata & zone_cfg_pkg::LATCH_MASK;
        zone_cfg_pkg::ADDR_STAGE_RESP: stage_resp <= reg_wdata[0];
        zone_cfg_pkg::ADDR_DIE_CFG: die_cfg <= reg_wdata[1:0];
        default: ; // read-only or unmapped: ignored
      endcase
    end
  end

  // selection follows the latches only while they agree
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      source_sel <= zone_cfg_pkg::LATCH_RST;
    else if (latch_a == latch_b)
      source_sel <= latch_a;
  end

  // read port: one-cycle answer, unmapped reads zero
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        unique case (reg_addr)
          zone_cfg_pkg::ADDR_SAVE_STATUS: reg_rdata <= {6'h00, save_s};
          zone_cfg_pkg::ADDR_PHASE_STATUS: reg_rdata <= phase_s;
          zone_cfg_pkg::ADDR_ZONE_ENABLES: reg_rdata <= {3'h0, zone_enables};
          zone_cfg_pkg::ADDR_ZONE_STATUS: reg_rdata <= {2'h0, zone_status};
          zone_cfg_pkg::ADDR_ZONE_CONFIG: reg_rdata <= {2'h0, zone_config};
          zone_cfg_pkg::ADDR_LOAD_LINE: reg_rdata <= {6'h00, load_line};
          zone_cfg_pkg::ADDR_SHED_CFG1: reg_rdata <= shed_cfg[0];
          zone_cfg_pkg::ADDR_SHED_STS1: reg_rdata <= shed_sts[0];
          zone_cfg_pkg::ADDR_SHED_CFG2: reg_rdata <= shed_cfg[1];
          zone_cfg_pkg::ADDR_SHED_STS2: reg_rdata <= shed_sts[1];
          zone_cfg_pkg::ADDR_SHED_CFG3: reg_rdata <= shed_cfg[2];
          zone_cfg_pkg::ADDR_SHED_STS3: reg_rdata <= shed_sts[2];
          zone_cfg_pkg::ADDR_SHED_CFG4: reg_rdata <= shed_cfg[3];
          zone_cfg_pkg::ADDR_SHED_STS4: reg_rdata <= shed_sts[3];
          zone_cfg_pkg::ADDR_SHED_HYST: reg_rdata <= shed_hyst;
          zone_cfg_pkg::ADDR_SHED_DELAY: reg_rdata <= shed_delay;
          zone_cfg_pkg::ADDR_LATCH_A: reg_rdata <= latch_a;
          zone_cfg_pkg::ADDR_LATCH_B: reg_rdata <= latch_b;
          zone_cfg_pkg::ADDR_SENSE_V: reg_rdata <= sense_v_s;
          zone_cfg_pkg::ADDR_STAGE_T: reg_rdata <= stage_t_s;
          zone_cfg_pkg::ADDR_STAGE_RESP: reg_rdata <= {7'h00, stage_resp};
          zone_cfg_pkg::ADDR_DIE_CFG: reg_rdata <= {6'h00, die_cfg};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // zone decode from the selected source
  always_comb
  begin
    if (source_sel[zone_cfg_pkg::SEL_ZONE])
    begin
      next_level_a = level_a_of(zone_config[5:3], low_zone_level_a);
      next_level_b = level_b_of(zone_config[2:0], low_zone_level_b);
    end
    else
    begin
      next_level_a = level_a_of(zone_status[5:3], low_zone_level_a);
      next_level_b = level_b_of(zone_status[2:0], low_zone_level_b);
    end
  end

  // applied zone settings and source-select outputs
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      zone_gate <= zone_cfg_pkg::ZONE_ENABLES_RST;
      low_zone_level_a <= 3'h0;
      low_zone_level_b <= 2'h0;
      load_line_select <= zone_cfg_pkg::LOAD_LINE_RST;
      switching_frequency_select <= 1'b0;
      soft_start_from_reg <= 1'b0;
      per_phase_current_limit <= 1'b0;
      die_thermal_enable <= 1'b0;
    end
    else
    begin
      zone_gate <= (save_s == zone_cfg_pkg::SAVE_LOW) ? zone_enables
        : zone_cfg_pkg::ZONE_ENABLES_RST;
      low_zone_level_a <= next_level_a;
      low_zone_level_b <= next_level_b;
      load_line_select <= load_line;
      switching_frequency_select <= source_sel[zone_cfg_pkg::SEL_FREQ];
      soft_start_from_reg <= source_sel[zone_cfg_pkg::SEL_SOFT];
      per_phase_current_limit <= source_sel[zone_cfg_pkg::SEL_ILIM];
      die_thermal_enable <= die_cfg[1];
    end
  end

  // thresholds in force and phase-step counts
  always_comb
  begin
    up_count = 3'h0;
    down_count = 3'h0;
    for (int i = 0; i < 4; i++)
    begin
      thr[i] = source_sel[zone_cfg_pkg::SEL_SHED] ? shed_cfg[i] : shed_sts[i];
      if (thr[i] != zone_cfg_pkg::SHED_OFF)
      begin
        if (iout_s >= thr[i])
          up_count = up_count + 3'h1;
        if ({1'b0, iout_s} + {1'b0, shed_hyst} >= {1'b0, thr[i]})
          down_count = down_count + 3'h1;
      end
    end
  end

  // delay in cycles; parameter scales it for short simulations
  assign delay_cycles = DLY_W'(shed_delay) * DLY_W'(SHED_STEP);

  // step up at once, step down only after the delay
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      shed_state <= zone_cfg_pkg::SHED_HOLD;
      shed_level <= 3'h0;
      shed_timer <= '0;
    end
    else if (up_count > shed_level)
    begin
      shed_level <= up_count;
      shed_state <= zone_cfg_pkg::SHED_HOLD;
      shed_timer <= '0;
    end
    else
    begin
      unique case (shed_state)
        zone_cfg_pkg::SHED_HOLD:
        begin
          shed_timer <= '0;
          if (down_count < shed_level)
            shed_state <= zone_cfg_pkg::SHED_WAIT;
        end
        zone_cfg_pkg::SHED_WAIT:
        begin
          // load went back up: abandon the step down
          if (down_count >= shed_level)
            shed_state <= zone_cfg_pkg::SHED_HOLD;
          else if (shed_timer >= delay_cycles)
          begin
            shed_level <= down_count;
            shed_state <= zone_cfg_pkg::SHED_HOLD;
          end
          else
            shed_timer <= shed_timer + DLY_W'(1);
        end
      endcase
    end
  end

  // thermal faults: latch off stays until reset, hiccup is a pulse
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stage_fault_d <= 1'b0;
      die_fault_d <= 1'b0;
      fault_latched_off <= 1'b0;
      fault_hiccup <= 1'b0;
    end
    else
    begin
      stage_fault_d <= stage_fault_s;
      die_fault_d <= die_fault_s;
      // stage fault response, die fault response
      fault_hiccup <= (stage_fault_s && !stage_fault_d && stage_resp)
        || (die_fault_s && !die_fault_d && die_cfg[1] && die_cfg[0]);
      if ((stage_fault_s && !stage_fault_d && !stage_resp)
        || (die_fault_s && !die_fault_d && die_cfg[1] && !die_cfg[0]))
        fault_latched_off <= 1'b1;
    end
  end

  property p_sel_match;
    @(posedge sys_clk) disable iff (rst)
    (latch_a == latch_b) |=> (source_sel == $past(latch_a));
  endproperty
  a_sel_match: assert property (p_sel_match) else $error("selection missed match");

  property p_sel_hold;
    @(posedge sys_clk) disable iff (rst)
    (latch_a != latch_b) |=> $stable(source_sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selection moved on mismatch");

  property p_gate;
    @(posedge sys_clk) disable iff (rst)
    (save_s != zone_cfg_pkg::SAVE_LOW) |=> (zone_gate == zone_cfg_pkg::ZONE_ENABLES_RST);
  endproperty
  a_gate: assert property (p_gate) else $error("zones gated outside low mode");

  property p_level_a;
    @(posedge sys_clk) disable iff (rst)
    (source_sel[zone_cfg_pkg::SEL_ZONE] && zone_config[5:3] <= zone_cfg_pkg::ZONE_A_MAX)
      |=> (low_zone_level_a == $past(zone_config[5:3]));
  endproperty
  a_level_a: assert property (p_level_a) else $error("first zone level wrong");

  property p_level_b;
    @(posedge sys_clk) disable iff (rst)
    (source_sel[zone_cfg_pkg::SEL_ZONE] && zone_config[2:0] == zone_cfg_pkg::ZONE_B_MAX)
      |=> (low_zone_level_b == zone_cfg_pkg::ZONE_B_TOP);
  endproperty
  a_level_b: assert property (p_level_b) else $error("second zone top code wrong");

  property p_shed_wait;
    @(posedge sys_clk) disable iff (rst)
    // any drop in phase count must come out of a completed wait
    (shed_level < $past(shed_level))
      |-> ($past(shed_state) == zone_cfg_pkg::SHED_WAIT)
      && ($past(shed_timer) >= $past(delay_cycles));
  endproperty
  a_shed_wait: assert property (p_shed_wait) else $error("shed without delay");

  property p_rdata_save;
    @(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == zone_cfg_pkg::ADDR_SAVE_STATUS)
      |=> reg_rvalid && (reg_rdata == {6'h00, $past(save_s)});
  endproperty
  a_rdata_save: assert property (p_rdata_save) else $error("power-save readout wrong");

  property p_latch_off;
    @(posedge sys_clk) disable iff (rst)
    fault_latched_off |=> fault_latched_off;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("latch-off released");

  property p_die_enable;
    @(posedge sys_clk) disable iff (rst)
    (!die_cfg[1] && !stage_fault_s) ##1 !die_cfg[1] |-> !fault_hiccup;
  endproperty
  a_die_enable: assert property (p_die_enable) else $error("die fault acted while off");

  property p_unmapped;
    @(posedge sys_clk) disable iff (rst)
    (reg_rd && (reg_addr == 8'h37 || reg_addr == 8'h42)) |=> (reg_rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

endmodule : phase_power_zone_config_regs

// *** verilog/zone_cfg_pkg.sv ***
package zone_cfg_pkg;
  // register offsets on the register port
  localparam logic [7:0] ADDR_SAVE_STATUS = 8'h32;
  localparam logic [7:0] ADDR_PHASE_STATUS = 8'h33;
  localparam logic [7:0] ADDR_ZONE_ENABLES = 8'h34;
  localparam logic [7:0] ADDR_ZONE_STATUS = 8'h35;
  localparam logic [7:0] ADDR_ZONE_CONFIG = 8'h36;
  localparam logic [7:0] ADDR_LOAD_LINE = 8'h39;
  localparam logic [7:0] ADDR_SHED_CFG1 = 8'h3a;
  localparam logic [7:0] ADDR_SHED_STS1 = 8'h3b;
  localparam logic [7:0] ADDR_SHED_CFG2 = 8'h3c;
  localparam logic [7:0] ADDR_SHED_STS2 = 8'h3d;
  localparam logic [7:0] ADDR_SHED_CFG3 = 8'h3e;
  localparam logic [7:0] ADDR_SHED_STS3 = 8'h3f;
  localparam logic [7:0] ADDR_SHED_CFG4 = 8'h40;
  localparam logic [7:0] ADDR_SHED_STS4 = 8'h41;
  localparam logic [7:0] ADDR_SHED_HYST = 8'h44;
  localparam logic [7:0] ADDR_SHED_DELAY = 8'h45;
  localparam logic [7:0] ADDR_LATCH_A = 8'h46;
  localparam logic [7:0] ADDR_LATCH_B = 8'h47;
  localparam logic [7:0] ADDR_SENSE_V = 8'h48;
  localparam logic [7:0] ADDR_STAGE_T = 8'h49;
  localparam logic [7:0] ADDR_STAGE_RESP = 8'h4a;
  localparam logic [7:0] ADDR_DIE_CFG = 8'h4b;
  // reset values
  localparam logic [4:0] ZONE_ENABLES_RST = 5'h1f;
  localparam logic [5:0] ZONE_CONFIG_RST = 6'h00;
  localparam logic [1:0] LOAD_LINE_RST = 2'h3;
  localparam logic [7:0] SHED_CFG_RST = 8'hff;
  localparam logic [7:0] SHED_HYST_RST = 8'h00;
  localparam logic [7:0] SHED_DELAY_RST = 8'h14;
  localparam logic [7:0] LATCH_RST = 8'h00;
  // writable bit masks, reserved bits stay zero
  localparam logic [7:0] LATCH_MASK = 8'h2f;
  // power-save input codes
  localparam logic [1:0] SAVE_MID = 2'h0;
  localparam logic [1:0] SAVE_LOW = 2'h1;
  localparam logic [1:0] SAVE_HIGH = 2'h2;
  // source-select latch bit positions
  localparam int SEL_SHED = 0;
  localparam int SEL_ZONE = 1;
  localparam int SEL_ILIM = 2;
  localparam int SEL_SOFT = 3;
  localparam int SEL_FREQ = 5;
  // zone code limits
  localparam logic [2:0] ZONE_A_MAX = 3'h4;
  localparam logic [2:0] ZONE_B_MAX = 3'h4;
  localparam logic [1:0] ZONE_B_TOP = 2'h3;
  // disabled threshold code
  localparam logic [7:0] SHED_OFF = 8'hff;
  // shedding delay step, 30 us per lsb at 100 MHz
  localparam int CLK_NS = 10;
  localparam int SHED_STEP_US = 30;
  localparam int SHED_STEP_CYCLES = SHED_STEP_US * 1000 / CLK_NS;
  // strap settle: sync depth before straps are caught
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  // shedding decision states
  typedef enum logic [0:0] {SHED_HOLD, SHED_WAIT} shed_state_t;
endpackage : zone_cfg_pkg

// *** verification/reg_host_model.sv ***
`timescale 1ns/1ns
// host side of the register port, one access at a time
module reg_host_model (
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // idle port from time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // one-cycle strobe; data scrambled once taken so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  // read answer is taken just after the edge that takes the strobe, while valid stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    v = reg_rvalid;
    d = reg_rdata;
  endtask : rd
  // source select written to both latches so they agree and the selection takes effect
  task automatic select_source(input logic [7:0] s);
    wr(8'h46, s);
    wr(8'h47, s);
  endtask : select_source
endmodule : reg_host_model

// *** verification/tb_phase_power_zone_config_regs.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_phase_power_zone_config_regs;
  logic sys_clk, rst, reg_wr, reg_rd, reg_rvalid, stage_thermal_fault, die_thermal_fault;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, phase_enabled, output_current_reading, d;
  logic [7:0] sense_voltage_code, stage_thermal_code;
  logic [7:0] strap [4];
  logic [1:0] power_save_input, low_zone_level_b, load_line_select;
  logic [2:0] zone_strap_a, zone_strap_b, low_zone_level_a, shed_level;
  logic [3:0] shed_strap_over_2v;
  logic [4:0] zone_gate;
  logic switching_frequency_select, soft_start_from_reg, per_phase_current_limit;
  logic die_thermal_enable, fault_latched_off, fault_hiccup;
  int n_errors = 0;
  int cmp_count = 0;
  int n_hic = 0;
  logic [31:0] seed = 32'h580501ee;
  // reset values: offset, expected byte (0x37 unmapped, 0x35 from straps 2 and 1)
  logic [15:0] rtab [15] = '{16'h341f, 16'h3600, 16'h3903, 16'h3aff, 16'h3cff, 16'h3eff,
    16'h40ff, 16'h4400, 16'h4514, 16'h4600, 16'h4700, 16'h4a00, 16'h4b00, 16'h3700, 16'h3511};
  // writable offsets and their implemented bits
  logic [15:0] mtab [9] = '{16'h341f, 16'h363f, 16'h3903, 16'h3aff, 16'h44ff, 16'h45ff,
    16'h462f, 16'h4a01, 16'h4b03};
  phase_power_zone_config_regs #(.SHED_STEP(4)) i_dut (.shed_strap1(strap[0]),
    .shed_strap2(strap[1]), .shed_strap3(strap[2]), .shed_strap4(strap[3]), .*);
  reg_host_model i_host (.*);
  // next random byte from the bench lfsr
  function logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  // read one register and compare
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] g;
    logic v;
    i_host.rd(a, g, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, g)
  endtask : chk_rd
  task automatic results();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // hiccup is a one-cycle pulse, so count every one
  always @(posedge sys_clk)
    if (fault_hiccup === 1'b1)
      n_hic++;
  // watchdog, run needs well under 100 us
  initial
  begin
    #100000;
    n_errors++;
    results();
  end
  initial
  begin
    rst = 1'b1;
    power_save_input = 2'h2;
    {phase_enabled, output_current_reading, sense_voltage_code, stage_thermal_code} = 32'h0;
    {stage_thermal_fault, die_thermal_fault} = 2'b00;
    zone_strap_a = 3'h2;
    zone_strap_b = 3'h1;
    shed_strap_over_2v = 4'h0;
    foreach (strap[i]) strap[i] = rnd() & 8'h7f;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    cyc(8);
    foreach (rtab[i]) chk_rd(rtab[i][15:8], rtab[i][7:0]);
    for (int i = 0; i < 4; i++) chk_rd(8'h3b + 8'(2 * i), strap[i]);
    // status inputs with random levels; a write to a status offset is dropped
    repeat (4)
    begin
      d = rnd() % 8'd3;
      power_save_input = d[1:0];
      phase_enabled = rnd();
      sense_voltage_code = rnd();
      stage_thermal_code = rnd();
      i_host.wr(8'h32, 8'hff);
      cyc(4);
      chk_rd(8'h32, {6'h0, power_save_input});
      chk_rd(8'h33, phase_enabled);
      chk_rd(8'h48, sense_voltage_code);
      chk_rd(8'h49, stage_thermal_code);
    end
    foreach (mtab[i])
    begin
      d = rnd();
      i_host.wr(mtab[i][15:8], d);
      chk_rd(mtab[i][15:8], d & mtab[i][7:0]);
    end
    for (int i = 0; i < 4; i++)
    begin
      i_host.wr(8'h39, 8'(i));
      cyc(2);
      `CHK("load_line", 2'(i), load_line_select)
    end
    // zone enables act only while the input is low
    i_host.wr(8'h34, 8'h15);
    power_save_input = 2'h1;
    cyc(4);
    `CHK("zone_gate", 5'h15, zone_gate)
    power_save_input = 2'h2;
    cyc(4);
    `CHK("zone_gate", 5'h1f, zone_gate)
    // one latch alone keeps the strapped zone
    i_host.wr(8'h36, 8'h24);
    i_host.wr(8'h46, 8'h2f);
    cyc(3);
    `CHK("level_a", 3'h2, low_zone_level_a)
    `CHK("level_b", 2'h1, low_zone_level_b)
    `CHK("freq_sel", 1'b0, switching_frequency_select)
    i_host.select_source(8'h2f);
    cyc(3);
    `CHK("level_a", 3'h4, low_zone_level_a)
    `CHK("level_b", 2'h3, low_zone_level_b)
    `CHK("sel_bits", 3'h7, {switching_frequency_select, soft_start_from_reg,
      per_phase_current_limit})
    i_host.wr(8'h36, 8'h2b);
    cyc(3);
    `CHK("level_a", 3'h4, low_zone_level_a)
    `CHK("level_b", 2'h3, low_zone_level_b)
    i_host.wr(8'h36, 8'h0a);
    cyc(3);
    `CHK("level_a", 3'h1, low_zone_level_a)
    `CHK("level_b", 2'h2, low_zone_level_b)
    // shedding from registers, hysteresis 8 codes, delay 2 steps
    i_host.wr(8'h3a, 8'h40);
    for (int i = 1; i < 4; i++) i_host.wr(8'h3a + 8'(2 * i), 8'hff);
    i_host.wr(8'h44, 8'h08);
    i_host.wr(8'h45, 8'h02);
    // full-scale load: only the one enabled threshold may count
    output_current_reading = 8'hff;
    cyc(4);
    `CHK("shed_up", 3'h1, shed_level)
    output_current_reading = 8'h3a;
    cyc(20);
    `CHK("shed_hyst", 3'h1, shed_level)
    output_current_reading = 8'h30;
    // two steps of 4 cycles: must still hold 9 cycles after the pin moved
    cyc(9);
    `CHK("shed_wait", 3'h1, shed_level)
    cyc(5);
    `CHK("shed_down", 3'h0, shed_level)
    // die fault ignored while disabled, then hiccup, then stage faults
    i_host.wr(8'h4b, 8'h00);
    i_host.wr(8'h4a, 8'h01);
    die_thermal_fault = 1'b1;
    cyc(5);
    `CHK("die_off", 0, n_hic)
    die_thermal_fault = 1'b0;
    i_host.wr(8'h4b, 8'h03);
    cyc(2);
    `CHK("die_en", 1'b1, die_thermal_enable)
    die_thermal_fault = 1'b1;
    cyc(5);
    `CHK("die_hic", 1, n_hic)
    stage_thermal_fault = 1'b1;
    cyc(5);
    `CHK("stage_hic", 2, n_hic)
    `CHK("latched", 1'b0, fault_latched_off)
    stage_thermal_fault = 1'b0;
    i_host.wr(8'h4a, 8'h00);
    stage_thermal_fault = 1'b1;
    cyc(5);
    `CHK("latched", 1'b1, fault_latched_off)
    `CHK("no_hic", 2, n_hic)
    // second cold start with straps 1 and 3 above 2 V; faults dropped first
    stage_thermal_fault = 1'b0;
    die_thermal_fault = 1'b0;
    shed_strap_over_2v = 4'h5;
    rst = 1'b1;
    cyc(6);
    rst = 1'b0;
    cyc(8);
    `CHK("latched", 1'b0, fault_latched_off)
    `CHK("sel_bits", 3'h0, {switching_frequency_select, soft_start_from_reg,
      per_phase_current_limit})
    chk_rd(8'h46, 8'h00);
    for (int i = 0; i < 4; i++) chk_rd(8'h3b + 8'(2 * i), i[0] ? strap[i] : 8'hff);
    // die fault with latch response while enabled
    i_host.wr(8'h4b, 8'h02);
    die_thermal_fault = 1'b1;
    cyc(5);
    `CHK("die_latch", 1'b1, fault_latched_off)
    `CHK("die_no_hic", 2, n_hic)
    results();
  end
endmodule : tb_phase_power_zone_config_regs
